// ===== design/fspr_pkg.sv
// Constants and types for the flash self-program access controller
package fspr_pkg;

   // ----------------------------------------------------------------
   // Flash geometry
   // ----------------------------------------------------------------
   localparam int         FSPR_AW          = 12;
   localparam logic [11:0] FSPR_CRR_LAST   = 12'hbff;
   localparam logic [11:0] FSPR_STALL_FIRST = 12'hc00;
   localparam logic [11:0] FSPR_STALL_LAST = 12'hfff;
   localparam logic [11:0] FSPR_APP_RESET  = 12'h000;

   // ----------------------------------------------------------------
   // Boot section starts per boot size code
   // ----------------------------------------------------------------
   localparam logic [11:0] FSPR_BOOT_SZ00 = 12'hc00;
   localparam logic [11:0] FSPR_BOOT_SZ01 = 12'he00;
   localparam logic [11:0] FSPR_BOOT_SZ10 = 12'hf00;
   localparam logic [11:0] FSPR_BOOT_SZ11 = 12'hf80;

   // ----------------------------------------------------------------
   // Page operation timing
   // ----------------------------------------------------------------
   localparam int FSPR_CLK_MHZ     = 250;
   localparam int FSPR_PROG_NS     = 64;
   localparam int FSPR_PROG_CYC    = (FSPR_PROG_NS * FSPR_CLK_MHZ + 999) / 1000;
   localparam int FSPR_CNT_W       = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] FSPR_A_STATUS = 4'h0;
   localparam logic [3:0] FSPR_A_MASK   = 4'h1;
   localparam logic [3:0] FSPR_A_CTRL   = 4'h2;

   // ----------------------------------------------------------------
   // Status event bit positions, width and reset value
   // ----------------------------------------------------------------
   localparam int FSPR_ST_REFUSED  = 0;
   localparam int FSPR_ST_DONE     = 1;
   localparam int FSPR_ST_IGNORED  = 2;
   localparam int FSPR_EV_W        = 3;
   localparam logic [2:0] FSPR_EV_RESET = 3'h0;

   typedef enum logic [1:0] {
      FSPR_IDLE,
      FSPR_PROG_CRR,
      FSPR_PROG_STALL
   } fspr_state_t;

   // Boot section start for a boot size code
   function automatic logic [11:0] fspr_boot_start(input logic [1:0] sz);
      logic [11:0] s;
      s = FSPR_BOOT_SZ00;
      unique case (sz)
         2'h0: s = FSPR_BOOT_SZ00;
         2'h1: s = FSPR_BOOT_SZ01;
         2'h2: s = FSPR_BOOT_SZ10;
         2'h3: s = FSPR_BOOT_SZ11;
      endcase
      return s;
   endfunction

   // Word address lies in the concurrent-read region
   function automatic logic fspr_in_crr(input logic [11:0] a);
      return a <= FSPR_CRR_LAST;
   endfunction

endpackage

// ===== design/fspr_timer.sv
// Page operation duration counter
`timescale 1ns/1ps
module fspr_timer
   import fspr_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic start,
   output logic      done
);

   logic [FSPR_CNT_W-1:0] cnt_r;
   logic [FSPR_CNT_W-1:0] cnt_nxt;
   logic                  done_r;
   logic                  done_nxt;

   always_comb begin
      cnt_nxt  = cnt_r;
      done_nxt = 1'b0;
      if (start) begin
         cnt_nxt = FSPR_CNT_W'(FSPR_PROG_CYC);
      end else if (cnt_r != '0) begin
         cnt_nxt  = cnt_r - 1'b1;
         done_nxt = (cnt_r == FSPR_CNT_W'(1));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign done = done_r;

endmodule

// ===== design/fspr_ctrl.sv
// Flash self-program access controller top
`timescale 1ns/1ps
//
// Function
// RL1: Ignore store from application section
// RL2: Boot section code may program any page
// RL3: Boot size fuses pick section boundary
// RL4: Lock bit 0 guards application section
// RL5: Lock bit 1 guards boot section
// RL6: CPU runs during concurrent-read page work
// RL7: Halt CPU during stall region page work
// RL8: Block concurrent-read reads while programming
// RL9: Busy flag high while region blocked
// RL10: Software clears busy flag before reading region
// RL11: Software avoids region during programming
// RL12: Boot section always inside stall region
// RL13: Fixed region boundaries at 0xc00
// RL14: Boot size code maps boot start
// RL15: Boot vector fuse selects reset address
// RL16: Pointer page picks region behaviour
// RL17: Refuse programming of locked section
module fspr_ctrl
   import fspr_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [1:0]  boot_size_fuses,
   input  wire logic        boot_vector_fuse_n,
   input  wire logic        app_lock_n,
   input  wire logic        boot_lock_n,
   input  wire logic        store_program_instr,
   input  wire logic [11:0] instr_pc,
   input  wire logic [11:0] page_ptr,
   input  wire logic        busy_clear,
   input  wire logic        code_rd,
   input  wire logic [11:0] code_rd_addr,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   output logic             irq,
   output logic             flash_op,
   output logic [11:0]      flash_op_page,
   output logic             cpu_halt,
   output logic             code_rd_block,
   output logic             region_busy_flag,
   output logic [11:0]      reset_vector
);

   fspr_state_t             st_r, st_nxt;
   logic                    op_r, op_nxt;
   logic [11:0]             page_r, page_nxt;
   logic                    halt_r, halt_nxt;
   logic                    blk_r, blk_nxt;
   logic                    busy_r, busy_nxt;
   logic [11:0]             rv_r, rv_nxt;
   logic [FSPR_EV_W-1:0]    stat_r, stat_nxt;
   logic [FSPR_EV_W-1:0]    mask_r, mask_nxt;
   logic [7:0]              rd_r, rd_nxt;
   logic                    irq_r, irq_nxt;
   logic                    done;
   logic [11:0]             boot_start;
   logic                    from_boot;
   logic                    tgt_boot;
   logic                    lock_ok;
   logic                    go;
   logic [FSPR_EV_W-1:0]    ev;

   fspr_timer u_timer (
      .clk_sys (clk_sys),
      .reset   (reset),
      .start   (go),
      .done    (done)
   );

   // ----------------------------------------------------------------
   // Command qualification
   // ----------------------------------------------------------------
   always_comb begin
      boot_start = fspr_boot_start(boot_size_fuses);  // RL3 RL14
      // Smallest start is the stall boundary, so boot stays inside
      from_boot  = instr_pc >= boot_start;            // RL12
      tgt_boot   = page_ptr >= boot_start;
      lock_ok    = tgt_boot ? boot_lock_n : app_lock_n; // RL4 RL5 RL17
      // Boot code may aim anywhere, boot pages included
      go = store_program_instr && from_boot && lock_ok
           && (st_r == FSPR_IDLE);                    // RL1 RL2
      ev = '0;
      ev[FSPR_ST_IGNORED] = store_program_instr && !from_boot; // RL1
      ev[FSPR_ST_REFUSED] = store_program_instr && from_boot
                            && !lock_ok;              // RL17
      ev[FSPR_ST_DONE]    = done;
   end

   // ----------------------------------------------------------------
   // Page operation sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt   = st_r;
      op_nxt   = 1'b0;
      page_nxt = page_r;
      halt_nxt = halt_r;
      blk_nxt  = blk_r;
      busy_nxt = busy_r;
      unique case (st_r)
         FSPR_IDLE: begin
            if (go) begin
               op_nxt   = 1'b1;
               page_nxt = page_ptr;                     // RL16
               blk_nxt  = 1'b1;                         // RL8
               busy_nxt = 1'b1;                         // RL9
               if (fspr_in_crr(page_ptr)) begin         // RL13 RL16
                  st_nxt = FSPR_PROG_CRR;               // RL6
               end else begin
                  st_nxt   = FSPR_PROG_STALL;
                  halt_nxt = 1'b1;                      // RL7
               end
            end
         end
         FSPR_PROG_CRR, FSPR_PROG_STALL: begin
            if (done) begin
               st_nxt   = FSPR_IDLE;
               halt_nxt = 1'b0;
            end
         end
      endcase
      // Region stays blocked until software releases it
      if (busy_clear && st_r == FSPR_IDLE && !go) begin // RL10
         busy_nxt = 1'b0;
         blk_nxt  = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Registers, interrupt and read path
   // ----------------------------------------------------------------
   always_comb begin
      rv_nxt   = boot_vector_fuse_n ? FSPR_APP_RESET : boot_start; // RL15
      mask_nxt = mask_r;
      if (reg_wr && reg_addr == FSPR_A_MASK) begin
         mask_nxt = reg_wdata[FSPR_EV_W-1:0];
      end
      stat_nxt = stat_r;
      rd_nxt   = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            FSPR_A_STATUS: begin
               rd_nxt   = {5'h00, stat_r};
               stat_nxt = '0;
            end
            FSPR_A_MASK: rd_nxt = {5'h00, mask_r};
            FSPR_A_CTRL: rd_nxt = {4'h0, halt_r, blk_r, busy_r,
                                   st_r != FSPR_IDLE};
            default:     rd_nxt = 8'h00;
         endcase
      end
      // A new event wins over the read clear
      stat_nxt = stat_nxt | ev;
      irq_nxt  = |(stat_nxt & mask_nxt);
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_r   <= FSPR_IDLE;
         op_r   <= 1'b0;
         page_r <= 12'h000;
         halt_r <= 1'b0;
         blk_r  <= 1'b0;
         busy_r <= 1'b0;
         rv_r   <= FSPR_APP_RESET;
         stat_r <= FSPR_EV_RESET;
         mask_r <= FSPR_EV_RESET;
         rd_r   <= 8'h00;
         irq_r  <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         op_r   <= op_nxt;
         page_r <= page_nxt;
         halt_r <= halt_nxt;
         blk_r  <= blk_nxt;
         busy_r <= busy_nxt;
         rv_r   <= rv_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         rd_r   <= rd_nxt;
         irq_r  <= irq_nxt;
      end
   end

   assign reg_rdata        = rd_r;
   assign irq              = irq_r;
   assign flash_op         = op_r;
   assign flash_op_page    = page_r;
   assign cpu_halt         = halt_r;
   assign code_rd_block    = blk_r;   // RL8
   assign region_busy_flag = busy_r;  // RL9
   assign reset_vector     = rv_r;

   // ----------------------------------------------------------------
   // Check helpers
   // ----------------------------------------------------------------
   // Halted cycles of the current run, to bound the halt span
   logic [FSPR_CNT_W-1:0]   halt_cnt_r;
   logic [FSPR_CNT_W-1:0]   halt_cnt_nxt;

   always_comb begin
      halt_cnt_nxt = '0;
      if (cpu_halt) begin
         halt_cnt_nxt = halt_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         halt_cnt_r <= '0;
      end else begin
         halt_cnt_r <= halt_cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_app_ignored: assert property ( // RL1
      @(posedge clk_sys) disable iff (reset)
      store_program_instr && instr_pc < boot_start |=> !flash_op)
      else $error("store from application started an operation");

   a_ignore_flag: assert property ( // RL1
      @(posedge clk_sys) disable iff (reset)
      store_program_instr && !from_boot |=> stat_r[FSPR_ST_IGNORED])
      else $error("ignored store not flagged");

   a_boot_starts: assert property ( // RL2
      @(posedge clk_sys) disable iff (reset)
      store_program_instr && from_boot && lock_ok && st_r == FSPR_IDLE
      |=> flash_op && flash_op_page == $past(page_ptr))
      else $error("boot store did not start operation");

   a_boot_self: assert property ( // RL2
      @(posedge clk_sys) disable iff (reset)
      store_program_instr && from_boot && tgt_boot && boot_lock_n
      && st_r == FSPR_IDLE |=> flash_op)
      else $error("boot store to boot page did not start");

   a_boot_map: assert property ( // RL3
      @(posedge clk_sys) disable iff (reset)
      boot_size_fuses == 2'h1 |-> boot_start == 12'he00)
      else $error("boot start wrong for size code one");

   a_app_lock: assert property ( // RL4
      @(posedge clk_sys) disable iff (reset)
      store_program_instr && !tgt_boot && !app_lock_n |=> !flash_op)
      else $error("locked application page programmed");

   a_boot_lock: assert property ( // RL5
      @(posedge clk_sys) disable iff (reset)
      store_program_instr && tgt_boot && !boot_lock_n |=> !flash_op)
      else $error("locked boot page programmed");

   a_refuse_flag: assert property ( // RL17
      @(posedge clk_sys) disable iff (reset)
      store_program_instr && from_boot && !lock_ok
      |=> stat_r[FSPR_ST_REFUSED])
      else $error("refused store not flagged");

   a_crr_runs: assert property ( // RL6
      @(posedge clk_sys) disable iff (reset)
      st_r == FSPR_PROG_CRR |-> !cpu_halt)
      else $error("cpu halted during concurrent-read work");

   a_crr_page: assert property ( // RL6 RL13
      @(posedge clk_sys) disable iff (reset)
      flash_op && flash_op_page <= FSPR_CRR_LAST |-> !cpu_halt)
      else $error("cpu halted for concurrent-read page");

   a_stall_halt: assert property ( // RL7 RL16
      @(posedge clk_sys) disable iff (reset)
      flash_op && flash_op_page >= FSPR_STALL_FIRST |-> cpu_halt)
      else $error("cpu not halted for stall page");

   a_stall_hold: assert property ( // RL7
      @(posedge clk_sys) disable iff (reset)
      st_r == FSPR_PROG_STALL |-> cpu_halt)
      else $error("cpu released during stall page work");

   a_halt_span: assert property ( // RL7
      @(posedge clk_sys) disable iff (reset)
      $fell(cpu_halt) |-> halt_cnt_r == FSPR_PROG_CYC + 1)
      else $error("halt span differs from page operation");

   a_busy_blk: assert property ( // RL8 RL9
      @(posedge clk_sys) disable iff (reset)
      flash_op |-> region_busy_flag && code_rd_block)
      else $error("region not blocked during operation");

   a_busy_active: assert property ( // RL9
      @(posedge clk_sys) disable iff (reset)
      st_r != FSPR_IDLE |-> region_busy_flag && code_rd_block)
      else $error("region not blocked while operation runs");

   a_busy_hold: assert property ( // RL9
      @(posedge clk_sys) disable iff (reset)
      region_busy_flag && !busy_clear |=> region_busy_flag)
      else $error("busy flag dropped without a clear");

   a_boot_inside: assert property ( // RL12
      @(posedge clk_sys) disable iff (reset)
      boot_start >= FSPR_STALL_FIRST)
      else $error("boot section reaches below stall region");

   a_boot_vec: assert property ( // RL15
      @(posedge clk_sys) disable iff (reset)
      !reset && !boot_vector_fuse_n |=> reset_vector >= FSPR_STALL_FIRST)
      else $error("boot vector outside stall region");

   a_app_vec: assert property ( // RL15
      @(posedge clk_sys) disable iff (reset)
      !reset && boot_vector_fuse_n |=> reset_vector == FSPR_APP_RESET)
      else $error("application vector not at origin");

endmodule

// ===== sim/fspr_cpu_model.sv
// Boot loader CPU model that issues page commands to the controller
`timescale 1ns/1ps
module fspr_cpu_model (
   input  wire logic  clk_sys,
   input  wire logic  region_busy_flag,
   output logic       store_program_instr,
   output logic [11:0] instr_pc,
   output logic [11:0] page_ptr,
   output logic       busy_clear,
   output logic       code_rd,
   output logic [11:0] code_rd_addr
);
   initial begin
      store_program_instr = 1'b0;
      instr_pc = 12'h000;
      page_ptr = 12'h000;
      busy_clear = 1'b0;
      code_rd = 1'b0;
      code_rd_addr = 12'hfff;
   end
   // Pointer and pc only hold with the pulse; inverted afterwards
   task automatic issue(input logic [11:0] pc, input logic [11:0] pg);
      @(posedge clk_sys);
      store_program_instr <= 1'b1;
      instr_pc <= pc;
      page_ptr <= pg;
      @(posedge clk_sys);
      store_program_instr <= 1'b0;
      instr_pc <= ~pc;
      page_ptr <= ~pg;
   endtask
   // Region code is fetched only once the busy flag has dropped
   task automatic release_region();
      @(posedge clk_sys);
      busy_clear <= 1'b1;
      @(posedge clk_sys);
      busy_clear <= 1'b0;
      @(posedge clk_sys);
      if (!region_busy_flag) begin
         code_rd <= 1'b1;
         code_rd_addr <= 12'h010;
      end
      @(posedge clk_sys);
      code_rd <= 1'b0;
      code_rd_addr <= 12'hfef;
   endtask
endmodule

// ===== sim/tb.sv
// Self-checking bench for the flash self-program access controller
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
   error_cnt++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
   logic        clk_sys, reset, boot_vector_fuse_n, app_lock_n, boot_lock_n;
   logic        store_program_instr, busy_clear, code_rd, reg_wr, reg_rd;
   logic        irq, flash_op, cpu_halt, code_rd_block, region_busy_flag;
   logic [1:0]  boot_size_fuses;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rd_v;
   logic [11:0] instr_pc, page_ptr, code_rd_addr, flash_op_page;
   logic [11:0] reset_vector;
   logic [11:0] boot_tab [4] = '{12'hc00, 12'he00, 12'hf00, 12'hf80};
   int          error_cnt = 0;
   int          check_count = 0;
   int          cyc = 0;

   fspr_ctrl u_fspr_ctrl (.clk_sys, .reset, .boot_size_fuses,
      .boot_vector_fuse_n, .app_lock_n, .boot_lock_n, .store_program_instr,
      .instr_pc, .page_ptr, .busy_clear, .code_rd, .code_rd_addr, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .flash_op,
      .flash_op_page, .cpu_halt, .code_rd_block, .region_busy_flag,
      .reset_vector);
   fspr_cpu_model u_fspr_cpu_model (.clk_sys, .region_busy_flag,
      .store_program_instr, .instr_pc, .page_ptr, .busy_clear, .code_rd,
      .code_rd_addr);

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Whole run is near 430 cycles; the ceiling leaves ample margin
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("errors=%0d checks=%0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask
   // One page command: start, mid-op, after done, release, status
   task automatic cmd(input logic [11:0] pc, input logic [11:0] pg,
                      input logic go, input logic hlt, input logic [7:0] st);
      u_fspr_cpu_model.issue(pc, pg);
      #1;
      `CHK({flash_op, cpu_halt, code_rd_block, region_busy_flag},
           {go, hlt, go, go})
      if (go) `CHK(flash_op_page, pg)
      repeat (10) @(posedge clk_sys);
      #1;
      `CHK({flash_op, cpu_halt, code_rd_block}, {1'b0, hlt, go})
      repeat (10) @(posedge clk_sys);
      #1;
      `CHK({cpu_halt, region_busy_flag}, {1'b0, go})
      u_fspr_cpu_model.release_region();
      #1;
      `CHK({code_rd_block, region_busy_flag}, 2'b00)
      rd(4'h0);
      `CHK(rd_v, st)
   endtask

   initial begin
      reset = 1'b1;
      boot_size_fuses = 2'h0;
      boot_vector_fuse_n = 1'b0;
      app_lock_n = 1'b1;
      boot_lock_n = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (12) @(posedge clk_sys);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys);
         boot_size_fuses <= i[1:0];
         boot_vector_fuse_n <= (i == 4);
         reset <= 1'b1;
         repeat (2) @(posedge clk_sys);
         reset <= 1'b0;
         repeat (2) @(posedge clk_sys);
         #1;
         `CHK(reset_vector, (i == 4) ? 12'h000 : boot_tab[i])
      end
      cmd(12'h100, 12'h200, 0, 0, 8'h04);
      cmd(12'hbff, 12'h200, 0, 0, 8'h04);
      cmd(12'hc00, 12'h040, 1, 0, 8'h02);
      cmd(12'hc10, 12'hbff, 1, 0, 8'h02);
      cmd(12'hc10, 12'hc00, 1, 1, 8'h02);
      app_lock_n <= 1'b0;
      cmd(12'hc10, 12'h300, 0, 0, 8'h01);
      cmd(12'hc10, 12'hd00, 1, 1, 8'h02);
      app_lock_n <= 1'b1;
      boot_lock_n <= 1'b0;
      cmd(12'hc10, 12'hc00, 0, 0, 8'h01);
      cmd(12'hc10, 12'h300, 1, 0, 8'h02);
      boot_lock_n <= 1'b1;
      boot_size_fuses <= 2'h3;
      cmd(12'hf7f, 12'h300, 0, 0, 8'h04);
      cmd(12'hf80, 12'hf80, 1, 1, 8'h02);
      // Interrupt: raise, mask, clear by status read
      wr(4'h1, 8'h07);
      rd(4'h1);
      `CHK(rd_v, 8'h07)
      u_fspr_cpu_model.issue(12'h100, 12'h200);
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(irq, 1'b1)
      wr(4'h1, 8'h03);
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(irq, 1'b0)
      wr(4'h1, 8'h07);
      rd(4'h0);
      `CHK(rd_v, 8'h04)
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK(irq, 1'b0)
      wr(4'h2, 8'hff);
      rd(4'h2);
      `CHK(rd_v, 8'h00)
      rd(4'hf);
      `CHK(rd_v, 8'h00)
      // Control view during work; a store while busy is dropped
      u_fspr_cpu_model.issue(12'hf80, 12'h040);
      rd(4'h2);
      `CHK(rd_v, 8'h07)
      u_fspr_cpu_model.issue(12'hf80, 12'h100);
      #1;
      `CHK(flash_op, 1'b0)
      repeat (20) @(posedge clk_sys);
      #1;
      `CHK({irq, region_busy_flag}, 2'b11)
      u_fspr_cpu_model.release_region();
      rd(4'h0);
      `CHK(rd_v, 8'h02)
      u_fspr_cpu_model.issue(12'hf80, 12'hfc0);
      rd(4'h2);
      `CHK(rd_v, 8'h0f)
      repeat (20) @(posedge clk_sys);
      u_fspr_cpu_model.release_region();
      #1;
      `CHK({cpu_halt, irq}, 2'b01)
      end_of_test();
   end
endmodule
